// *** meas_trig.sv ***
// Measurement-acquire trigger: level/hysteresis/slope per channel, source select,
// initiate gating and repeat count. Settings are registers here, loaded by the caller's
// strobes; samples come from a converter on the core clock.
// How it works
// [RULE_01] Band spans level minus half width to level plus half width.
// [RULE_02] Rising crossing needs a sample below band, then above it.
// [RULE_03] Falling crossing needs a sample above band, then below it.
// [RULE_04] Current trigger level register resets to zero.
// [RULE_05] Voltage trigger level register resets to zero.
// [RULE_06] Aux voltmeter level resets to zero and uses the same band logic.
// [RULE_07] Aux voltmeter hysteresis width resets to zero.
// [RULE_08] Voltage hysteresis width resets to zero.
// [RULE_09] Rising slope fires only on rising crossings.
// [RULE_10] Falling slope fires only on falling crossings.
// [RULE_11] Either slope fires on both crossing directions.
// [RULE_12] Current slope resets to rising.
// [RULE_13] Voltage slope resets to rising.
// [RULE_14] Aux voltmeter slope resets to rising.
// [RULE_15] Source is bus or internal; internal after reset.
// [RULE_16] Internal source triggers on allowed crossing of the selected quantity.
// [RULE_17] Sequence 1 is transient, sequence 2 acquire; fixed, queryable.
// [RULE_18] Host selects the monitored quantity before triggering.
// [RULE_19] After each measurement wait again until count 1..100 is spent.
// [RULE_20] Triggers are ignored unless the system was initiated.
// [RULE_21] Per-channel armed state set leaving band, cleared on trigger.
`timescale 1ns/100ps
module meas_trig
    import meas_trig_pkg::*;
#(
    parameter int unsigned W = DATA_W,
    parameter int unsigned CW = COUNT_W
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Setting writes, one strobe per setting
    input wire logic i_wr_level_curr,
    input wire logic i_wr_level_volt,
    input wire logic i_wr_level_aux,
    input wire logic i_wr_hyst_curr,
    input wire logic i_wr_hyst_volt,
    input wire logic i_wr_hyst_aux,
    input wire logic i_wr_slope_curr,
    input wire logic i_wr_slope_volt,
    input wire logic i_wr_slope_aux,
    input wire logic i_wr_source,
    input wire logic i_wr_func,
    input wire logic i_wr_count,
    input wire logic [W-1:0] i_wr_value,
    input wire slope_t i_wr_slope,
    input wire source_t i_wr_src,
    input wire func_t i_wr_fn,
    input wire logic [CW-1:0] i_wr_cnt,
    input wire logic i_wr_define,
    input wire logic i_define_seq,
    input wire seq_name_t i_define_name,
    input wire logic i_query_seq,
    // Control events
    input wire logic i_initiate,
    input wire logic i_abort,
    input wire logic i_bus_trigger,
    // Samples
    input wire logic i_sample_valid,
    input wire logic [W-1:0] i_volt_sample,
    input wire logic [W-1:0] i_curr_sample,
    input wire logic [W-1:0] i_aux_voltmeter_input,
    // Results
    output logic o_meas_trigger,
    output logic o_waiting,
    output logic o_define_error,
    output seq_name_t o_query_name,
    output logic [CW-1:0] o_remaining,
    output logic [W-1:0] o_level_curr,
    output logic [W-1:0] o_level_volt,
    output logic [W-1:0] o_level_aux,
    output logic [W-1:0] o_hyst_curr,
    output logic [W-1:0] o_hyst_volt,
    output logic [W-1:0] o_hyst_aux,
    output slope_t o_slope_curr,
    output slope_t o_slope_volt,
    output slope_t o_slope_aux,
    output source_t o_source,
    output func_t o_func,
    output logic [CW-1:0] o_count
);
    logic [W-1:0] level_curr_q;
    logic [W-1:0] level_volt_q;
    logic [W-1:0] level_aux_q;
    logic [W-1:0] hyst_curr_q;
    logic [W-1:0] hyst_volt_q;
    logic [W-1:0] hyst_aux_q;
    slope_t slope_curr_q;
    slope_t slope_volt_q;
    slope_t slope_aux_q;
    source_t source_q;
    func_t func_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] remaining_q;
    logic waiting_q;
    logic trig_q;
    logic define_err_q;
    seq_name_t query_q;
    logic fire_volt;
    logic fire_curr;
    logic fire_aux;
    logic int_fire;
    logic take;
    logic chan_enable;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_curr_q <= LEVEL_RESET; // [RULE_04]
            level_volt_q <= LEVEL_RESET; // [RULE_05]
            level_aux_q <= LEVEL_RESET; // [RULE_06]
        end else begin
            if (i_wr_level_curr) level_curr_q <= i_wr_value;
            if (i_wr_level_volt) level_volt_q <= i_wr_value;
            if (i_wr_level_aux) level_aux_q <= i_wr_value;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hyst_curr_q <= HYST_RESET;
            hyst_volt_q <= HYST_RESET; // [RULE_08]
            hyst_aux_q <= HYST_RESET; // [RULE_07]
        end else begin
            if (i_wr_hyst_curr) hyst_curr_q <= i_wr_value;
            if (i_wr_hyst_volt) hyst_volt_q <= i_wr_value;
            if (i_wr_hyst_aux) hyst_aux_q <= i_wr_value;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            slope_curr_q <= SLOPE_RESET; // [RULE_12]
            slope_volt_q <= SLOPE_RESET; // [RULE_13]
            slope_aux_q <= SLOPE_RESET; // [RULE_14]
        end else begin
            // Unused encoding refused so slope always stays legal
            if (i_wr_slope_curr && i_wr_slope != 2'b11) slope_curr_q <= i_wr_slope;
            if (i_wr_slope_volt && i_wr_slope != 2'b11) slope_volt_q <= i_wr_slope;
            if (i_wr_slope_aux && i_wr_slope != 2'b11) slope_aux_q <= i_wr_slope;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            source_q <= SOURCE_RESET; // [RULE_15]
            func_q <= FUNC_VOLTAGE;
            count_q <= COUNT_RESET;
        end else begin
            if (i_wr_source) source_q <= i_wr_src; // [RULE_15]
            if (i_wr_func && i_wr_fn != 2'b11) func_q <= i_wr_fn; // [RULE_18]
            // Out-of-range counts are refused, keeping the old value
            if (i_wr_count && i_wr_cnt >= COUNT_MIN && i_wr_cnt <= COUNT_MAX) begin
                count_q <= i_wr_cnt; // [RULE_19]
            end
        end
    end

    // Sequence names are fixed; a mismatching define only flags an error
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            define_err_q <= 1'b0;
            query_q <= NAME_TRANSIENT;
        end else begin
            define_err_q <= i_wr_define
                && ((i_define_seq ? NAME_ACQUIRE : NAME_TRANSIENT) != i_define_name); // [RULE_17]
            query_q <= i_query_seq ? NAME_ACQUIRE : NAME_TRANSIENT; // [RULE_17]
        end
    end

    // Only the selected quantity's detector runs; others are held disarmed
    assign chan_enable = waiting_q && (source_q == SRC_INTERNAL);

    band_detector #(.W(W)) u_det_volt (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(chan_enable && func_q == FUNC_VOLTAGE),
        .i_level(level_volt_q),
        .i_hyst(hyst_volt_q),
        .i_slope(slope_volt_q),
        .i_sample_valid(i_sample_valid),
        .i_sample(i_volt_sample),
        .o_fire(fire_volt),
        .o_armed_low(),
        .o_armed_high()
    );

    band_detector #(.W(W)) u_det_curr (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(chan_enable && func_q == FUNC_CURRENT),
        .i_level(level_curr_q),
        .i_hyst(hyst_curr_q),
        .i_slope(slope_curr_q),
        .i_sample_valid(i_sample_valid),
        .i_sample(i_curr_sample),
        .o_fire(fire_curr),
        .o_armed_low(),
        .o_armed_high()
    );

    band_detector #(.W(W)) u_det_aux (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(chan_enable && func_q == FUNC_AUX), // [RULE_06]
        .i_level(level_aux_q),
        .i_hyst(hyst_aux_q),
        .i_slope(slope_aux_q),
        .i_sample_valid(i_sample_valid),
        .i_sample(i_aux_voltmeter_input),
        .o_fire(fire_aux),
        .o_armed_low(),
        .o_armed_high()
    );

    assign int_fire = fire_volt || fire_curr || fire_aux; // [RULE_16]
    // Abort wins over any trigger in the same cycle
    assign take = waiting_q && !i_abort
        && ((source_q == SRC_BUS) ? i_bus_trigger : int_fire); // [RULE_20] [RULE_15]

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            waiting_q <= 1'b0;
            remaining_q <= '0;
        end else if (i_abort) begin
            waiting_q <= 1'b0;
            remaining_q <= '0;
        end else if (i_initiate && !waiting_q) begin
            waiting_q <= 1'b1;
            remaining_q <= count_q; // [RULE_19]
        end else if (take) begin
            remaining_q <= remaining_q - 1'b1; // [RULE_19]
            waiting_q <= (remaining_q != COUNT_MIN); // [RULE_19]
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= take; // [RULE_16]
        end
    end

    assign o_meas_trigger = trig_q;
    assign o_waiting = waiting_q;
    assign o_define_error = define_err_q;
    assign o_query_name = query_q;
    assign o_remaining = remaining_q;
    assign o_level_curr = level_curr_q;
    assign o_level_volt = level_volt_q;
    assign o_level_aux = level_aux_q;
    assign o_hyst_curr = hyst_curr_q;
    assign o_hyst_volt = hyst_volt_q;
    assign o_hyst_aux = hyst_aux_q;
    assign o_slope_curr = slope_curr_q;
    assign o_slope_volt = slope_volt_q;
    assign o_slope_aux = slope_aux_q;
    assign o_source = source_q;
    assign o_func = func_q;
    assign o_count = count_q;
endmodule // meas_trig

// *** meas_trig_pkg.sv ***
// Constants and types for the measurement-acquire trigger block.
// Assumes samples arrive as unsigned codes on the core clock.
package meas_trig_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned COUNT_W = 7;

    typedef enum logic [1:0] {
        SLOPE_RISING,
        SLOPE_FALLING,
        SLOPE_EITHER
    } slope_t;

    typedef enum logic [1:0] {
        FUNC_VOLTAGE,
        FUNC_CURRENT,
        FUNC_AUX
    } func_t;

    typedef enum logic {
        SRC_INTERNAL,
        SRC_BUS
    } source_t;

    typedef enum logic {
        NAME_TRANSIENT,
        NAME_ACQUIRE
    } seq_name_t;

    localparam logic [DATA_W-1:0] LEVEL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] HYST_RESET = 16'h0000;
    localparam slope_t SLOPE_RESET = SLOPE_RISING;
    localparam source_t SOURCE_RESET = SRC_INTERNAL;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h01;
    localparam logic [COUNT_W-1:0] COUNT_MIN = 7'h01;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h64;

endpackage

// *** band_detector.sv ***
// One channel of hysteresis band crossing detection.
// Assumes level, width and sample are unsigned codes on the core clock.
`timescale 1ns/100ps
module band_detector
    import meas_trig_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [W-1:0] i_level,
    input wire logic [W-1:0] i_hyst,
    input wire slope_t i_slope,
    input wire logic i_sample_valid,
    input wire logic [W-1:0] i_sample,
    output logic o_fire,
    output logic o_armed_low,
    output logic o_armed_high
);
    logic [W:0] upper;
    logic [W:0] lower_ext;
    logic below;
    logic above;
    logic rise_hit;
    logic fall_hit;
    logic want_rise;
    logic want_fall;

    // Extra bit keeps level + width/2 from wrapping; lower saturates at zero
    assign upper = {1'b0, i_level} + {2'b00, i_hyst[W-1:1]}; // [RULE_01]
    assign lower_ext = {1'b0, i_level} - {2'b00, i_hyst[W-1:1]}; // [RULE_01]
    assign below = !lower_ext[W] && ({1'b0, i_sample} < lower_ext);
    assign above = {1'b0, i_sample} > upper;

    assign want_rise = (i_slope == SLOPE_RISING) || (i_slope == SLOPE_EITHER); // [RULE_09] [RULE_11]
    assign want_fall = (i_slope == SLOPE_FALLING) || (i_slope == SLOPE_EITHER); // [RULE_10] [RULE_11]
    assign rise_hit = i_sample_valid && o_armed_low && above; // [RULE_02]
    assign fall_hit = i_sample_valid && o_armed_high && below; // [RULE_03]

    // Armed flags track which side of the band was seen last
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_armed_low <= 1'b0;
            o_armed_high <= 1'b0;
        end else if (!i_enable) begin
            o_armed_low <= 1'b0;
            o_armed_high <= 1'b0;
        end else if (i_sample_valid) begin
            if (below) begin
                o_armed_low <= 1'b1; // [RULE_21]
                o_armed_high <= 1'b0;
            end else if (above) begin
                o_armed_high <= 1'b1; // [RULE_21]
                o_armed_low <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fire <= 1'b0;
        end else begin
            o_fire <= i_enable && ((rise_hit && want_rise) || (fall_hit && want_fall));
        end
    end
endmodule // band_detector

// *** bus_host_model.sv ***
// Host model that issues bus measurement triggers.
// Shares the core clock; a pulse on i_go starts a burst of i_burst triggers.
`timescale 1ns/100ps
module bus_host_model (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_go,
    input wire logic [6:0] i_burst,
    output logic o_bus_trigger
);
    logic [6:0] left_q;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            left_q <= 7'h00;
        end else if (i_go) begin
            left_q <= i_burst;
        end else if (left_q != 7'h00) begin
            left_q <= left_q - 7'h01;
        end
    end
    // Back to back, one trigger per cycle, the harshest legal spacing
    assign o_bus_trigger = (left_q != 7'h00);
endmodule // bus_host_model

// *** meas_trig_props.sv ***
// Port-level checks of the measurement trigger block.
// Bound to meas_trig; sees its ports only.
`timescale 1ns/100ps
module meas_trig_props
    import meas_trig_pkg::*;
#(
    parameter int unsigned CW = COUNT_W
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_initiate,
    input wire logic i_abort,
    input wire logic i_bus_trigger,
    input wire logic i_wr_define,
    input wire logic i_define_seq,
    input wire seq_name_t i_define_name,
    input wire logic i_query_seq,
    input wire logic o_meas_trigger,
    input wire logic o_waiting,
    input wire logic o_define_error,
    input wire seq_name_t o_query_name,
    input wire logic [CW-1:0] o_remaining,
    input wire source_t o_source,
    input wire logic [CW-1:0] o_count
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_no_idle_trig: assert property (o_meas_trigger |-> $past(o_waiting))
        else $error("trigger while idle");
    a_bus_answer: assert property (o_waiting && o_source == SRC_BUS && i_bus_trigger
        && !i_abort |=> o_meas_trigger) else $error("bus trigger lost");
    a_count_step: assert property (o_meas_trigger |->
        o_remaining == $past(o_remaining) - 1'b1) else $error("count not stepped");
    a_last_stops: assert property (o_meas_trigger && o_remaining == '0 |-> !o_waiting)
        else $error("still waiting after last");
    a_init_load: assert property (!o_waiting && i_initiate && !i_abort |=>
        o_waiting && o_remaining == $past(o_count)) else $error("initiate not taken");
    a_abort_idle: assert property (i_abort |=> !o_waiting && !o_meas_trigger)
        else $error("abort ignored");
    a_define_check: assert property ($past(i_reset_n) |-> o_define_error ==
        ($past(i_wr_define) && $past(i_define_seq) != $past(i_define_name)))
        else $error("define error wrong");
    a_query_ans: assert property ($past(i_reset_n) |->
        o_query_name == $past(i_query_seq)) else $error("query name wrong");
endmodule // meas_trig_props

// *** meas_trig_test.sv ***
// Bench for meas_trig: readbacks, band crossings, bus burst, naming.
// Inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/100ps
module meas_trig_test;
    import meas_trig_pkg::*;
    typedef struct {int s; logic [15:0] v; logic [15:0] e;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] wr = 12'h000;
    logic [3:0] ctl = 4'h0;
    logic [15:0] val = 16'h0000;
    logic [15:0] sm [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic sv = 1'b0;
    logic dseq = 1'b0;
    logic qseq = 1'b0;
    seq_name_t dname = NAME_TRANSIENT;
    logic trig, waiting, derr, btrig;
    seq_name_t qname;
    logic [6:0] rem, cnt;
    logic [15:0] lc, lv, la, hc, hv, ha;
    slope_t scur, svol, saux;
    source_t src;
    func_t fn;
    logic [15:0] rbv [12];
    int n_fail = 0;
    int samples_checked = 0;
    int ntrig = 0;
    int nerr = 0;
    int base;
    // Band is 0x5a..0x6e; edges of the band must not count as outside
    logic [15:0] smp [6] = '{16'h0078, 16'h0059, 16'h006e, 16'h006f, 16'h005a, 16'h0059};
    row_t rows [16] = '{'{0, 16'h1234, 16'h1234}, '{1, 16'hffff, 16'hffff},
        '{2, 16'h0abc, 16'h0abc}, '{3, 16'h0055, 16'h0055}, '{4, 16'h8000, 16'h8000},
        '{5, 16'h0007, 16'h0007}, '{6, 16'h0002, 16'h0002}, '{6, 16'h0003, 16'h0002},
        '{7, 16'h0001, 16'h0001}, '{8, 16'h0002, 16'h0002}, '{9, 16'h0001, 16'h0001},
        '{10, 16'h0002, 16'h0002}, '{10, 16'h0003, 16'h0002}, '{11, 16'h0064, 16'h0064},
        '{11, 16'h0065, 16'h0064}, '{11, 16'h0000, 16'h0064}};
    assign rbv = '{lc, lv, la, hc, hv, ha, 16'(scur), 16'(svol), 16'(saux), 16'(src),
        16'(fn), 16'(cnt)};
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (trig === 1'b1) ntrig <= ntrig + 1;
        if (derr === 1'b1) nerr <= nerr + 1;
    end
    meas_trig dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_wr_level_curr(wr[0]),
        .i_wr_level_volt(wr[1]), .i_wr_level_aux(wr[2]), .i_wr_hyst_curr(wr[3]),
        .i_wr_hyst_volt(wr[4]), .i_wr_hyst_aux(wr[5]), .i_wr_slope_curr(wr[6]),
        .i_wr_slope_volt(wr[7]), .i_wr_slope_aux(wr[8]), .i_wr_source(wr[9]),
        .i_wr_func(wr[10]), .i_wr_count(wr[11]), .i_wr_value(val),
        .i_wr_slope(slope_t'(val[1:0])), .i_wr_src(source_t'(val[0])),
        .i_wr_fn(func_t'(val[1:0])), .i_wr_cnt(val[6:0]), .i_wr_define(ctl[0]),
        .i_define_seq(dseq), .i_define_name(dname), .i_query_seq(qseq),
        .i_initiate(ctl[1]), .i_abort(ctl[2]), .i_bus_trigger(btrig), .i_sample_valid(sv),
        .i_volt_sample(sm[0]), .i_curr_sample(sm[1]), .i_aux_voltmeter_input(sm[2]),
        .o_meas_trigger(trig), .o_waiting(waiting), .o_define_error(derr),
        .o_query_name(qname), .o_remaining(rem), .o_level_curr(lc), .o_level_volt(lv),
        .o_level_aux(la), .o_hyst_curr(hc), .o_hyst_volt(hv), .o_hyst_aux(ha),
        .o_slope_curr(scur), .o_slope_volt(svol), .o_slope_aux(saux), .o_source(src),
        .o_func(fn), .o_count(cnt));
    bus_host_model host (.i_core_clk(clk), .i_reset_n(rst_n), .i_go(ctl[3]),
        .i_burst(val[6:0]), .o_bus_trigger(btrig));
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(int s, logic [15:0] v);
        wr <= 12'h001 << s;
        val <= v;
        @(posedge clk);
        wr <= 12'h000;
        @(posedge clk);
    endtask
    task automatic ev(int b);
        ctl <= 4'h1 << b;
        @(posedge clk);
        ctl <= 4'h0;
        @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 50 && waiting !== 1'b0; k++) @(posedge clk);
        if (k == 50) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // Every readback against its value after reset
    task automatic check_defaults();
        for (int i = 0; i < 3; i++) chk(rbv[i], LEVEL_RESET);
        for (int i = 3; i < 6; i++) chk(rbv[i], HYST_RESET);
        for (int i = 6; i < 9; i++) chk(rbv[i], SLOPE_RESET);
        chk(rbv[9], SOURCE_RESET);
        chk(rbv[10], FUNC_VOLTAGE);
        chk(rbv[11], COUNT_RESET);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_defaults();
        chk(16'(waiting), 16'h0000);
        $display("done: reset");
        foreach (rows[i]) begin
            put(rows[i].s, rows[i].v);
            chk(rbv[rows[i].s], rows[i].e);
        end
        $display("done: settings");
        put(9, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            put(c, 16'h0064);
            put(3 + c, 16'h0014);
        end
        for (int f = 0; f < 3; f++) begin
            for (int s = 0; s < 3; s++) begin
                put(f == 0 ? 7 : f == 1 ? 6 : 8, 16'(s));
                put(10, 16'(f));
                ev(1);
                base = ntrig;
                foreach (smp[i]) begin
                    foreach (sm[j]) sm[j] <= (j == f) ? smp[i] : 16'h0000;
                    sv <= 1'b1;
                    @(posedge clk);
                end
                sv <= 1'b0;
                repeat (5) @(posedge clk);
                // Samples give one rising and two falling crossings; band edges are inside
                if (s == 0) chk(16'(ntrig - base), 16'h0001);
                else if (s == 1) chk(16'(ntrig - base), 16'h0002);
                else chk(16'(ntrig - base), 16'h0003);
                ev(2);
            end
        end
        $display("done: crossings");
        put(9, 16'h0001);
        put(11, 16'h0003);
        base = ntrig;
        ev(3);
        repeat (5) @(posedge clk);
        chk(16'(ntrig - base), 16'h0000);
        ev(1);
        chk(16'(rem), 16'h0003);
        ev(3);
        wait_idle();
        repeat (3) @(posedge clk);
        chk(16'(ntrig - base), 16'h0003);
        chk(16'(rem), 16'h0000);
        $display("done: bus burst");
        for (int d = 0; d < 4; d++) begin
            dseq <= d[1];
            qseq <= d[1];
            dname <= seq_name_t'(d[0]);
            base = nerr;
            ev(0);
            repeat (2) @(posedge clk);
            chk(16'(nerr - base), 16'(d[1] ^ d[0]));
            chk(16'(qname), 16'(d[1]));
        end
        $display("done: naming");
        // One bus trigger of three, then an initiate that must be ignored
        ev(1);
        val <= 16'h0001;
        ev(3);
        ev(1);
        chk(16'(rem), 16'h0002);
        chk(16'(waiting), 16'h0001);
        $display("done: re-initiate");
        // Reset in mid-run, while waiting, with every setting away from its default
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_defaults();
        chk(16'(waiting), 16'h0000);
        chk(16'(rem), 16'h0000);
        $display("done: reset again");
        end_of_test();
    end
endmodule // meas_trig_test
bind meas_trig meas_trig_props #(.CW(CW)) chk (.i_core_clk, .i_reset_n, .i_initiate,
    .i_abort, .i_bus_trigger, .i_wr_define, .i_define_seq, .i_define_name, .i_query_seq,
    .o_meas_trigger, .o_waiting, .o_define_error, .o_query_name, .o_remaining,
    .o_source, .o_count);
